// ==== logic/gsp_params.svh ====
`ifndef GSP_PARAMS_SVH
`define GSP_PARAMS_SVH

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define GSP_PADDR_W      8
`define GSP_OFF_STATUS   8'h00
`define GSP_OFF_CTRL     8'h04
`define GSP_OFF_SUSP     8'h08
`define GSP_OFF_LAST     8'h0c
`define GSP_OFF_SECT0    8'h10
`define GSP_OFF_SECT3    8'h1c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define GSP_BIT_LOCK     7
`define GSP_PAT_HI       5
`define GSP_PAT_LO       2
`define GSP_ST_WP        4
`define GSP_ST_SWP_HI    3
`define GSP_ST_SWP_LO    2
`define GSP_ST_WEL       1
`define GSP_CTRL_WEL_SET 0
`define GSP_CTRL_WEL_CLR 1
`define GSP_SUSP_BIT     0

// ----------------------------------------
// Values
// ----------------------------------------
`define GSP_PAT_ONES     4'hf
`define GSP_PAT_ZERO     4'h0
`define GSP_SWP_ALL      2'h3
`define GSP_SWP_SOME     2'h1
`define GSP_SWP_NONE     2'h0
`define GSP_SECT_RST     32'hffffffff
`define GSP_SECT_CLR     32'h00000000
`define GSP_SECT_WORDS   4
`define GSP_OPCODE_DEF   8'h01

// ----------------------------------------
// Link bit counts
// ----------------------------------------
`define GSP_OPC_LAST     5'h07
`define GSP_DATA_LAST    5'h0f
`define GSP_FRAME_BITS   5'h10
`define GSP_CNT_WRAP     5'h17

`endif

// ==== logic/gsp_pkg.sv ====
`default_nettype none
package gsp_pkg;
  // Outcome of the most recent status byte write
  typedef enum logic [2:0] {
    GSP_ACT_NONE,
    GSP_ACT_UNPROT,
    GSP_ACT_PROT,
    GSP_ACT_KEEP,
    GSP_ACT_HWLOCK,
    GSP_ACT_SOFTLOCK,
    GSP_ACT_ABORT,
    GSP_ACT_NOWEL
  } gsp_act_t;
endpackage
`default_nettype wire

// ==== logic/gsp_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
module gsp_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Levels
  input  wire logic din,
  output logic      dout
);
  import gsp_pkg::*;

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic out_ff;
  logic nxt_out;

  // ----------------------------------------
  // Three stages, change taken when two agree
  // ----------------------------------------
  always_comb
  begin
    nxt_out = (s2_ff == s3_ff) ? s3_ff : out_ff;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_ff  <= 1'b0;
      s2_ff  <= 1'b0;
      s3_ff  <= 1'b0;
      out_ff <= 1'b0;
    end
    else
    begin
      s1_ff  <= din;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      out_ff <= nxt_out;
    end
  end

  assign dout = out_ff;
endmodule
`default_nettype wire

// ==== logic/gsp_decode.sv ====
//
// Contract
// - Unlocked write pattern 1111 protects all sectors
// - Unlocked write pattern 0000 unprotects all sectors
// - Other patterns leave sector bits unchanged
// - Lock clear: load lock bit, apply decode
// - Pin low, lock set: change nothing
// - Pin high, lock set: load lock only
// - Protect during suspend aborts, clears enable latch
// - Pattern bits decoded, never stored; read status
// - Hardware lock needs pin low and lock
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "gsp_params.svh"
module gsp_decode #(
  parameter logic [7:0] STATUS_WR_OPCODE = `GSP_OPCODE_DEF
) (
  // APB slave
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic [`GSP_PADDR_W-1:0] paddr,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Serial link and pins
  input  wire logic                    sclk,
  input  wire logic                    cs_n,
  input  wire logic                    si,
  input  wire logic                    wp_n,
  // Device state
  output logic      [127:0]            sect_prot,
  output logic                         protection_regs_locked,
  output logic                         write_enable_latch,
  output gsp_pkg::gsp_act_t            last_action
);
  import gsp_pkg::*;

  // ----------------------------------------
  // Link side, on the serial clock
  // ----------------------------------------
  logic       frame_rst_n;
  logic [4:0] bitcnt_ff;
  logic [4:0] nxt_bitcnt;
  logic [7:0] shift_ff;
  logic [7:0] nxt_shift;
  logic       opc_ok_ff;
  logic       nxt_opc_ok;
  logic [7:0] data_ff;
  logic [7:0] nxt_data;
  logic       got_ff;
  logic       nxt_got;
  logic       frame_ok_ff;
  logic       nxt_frame_ok;
  logic       seq_ff;
  logic       nxt_seq;

  // Frame counters die with chip select; captured byte survives it
  assign frame_rst_n = presetn & ~cs_n;

  always_comb
  begin
    nxt_shift  = {shift_ff[6:0], si};
    nxt_bitcnt = (bitcnt_ff == `GSP_CNT_WRAP) ? `GSP_FRAME_BITS : bitcnt_ff + 5'h01;
    nxt_opc_ok = opc_ok_ff;
    if (bitcnt_ff == `GSP_OPC_LAST)
    begin
      nxt_opc_ok = (nxt_shift == STATUS_WR_OPCODE);
    end
  end

  always_ff @(posedge sclk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      bitcnt_ff <= 5'h00;
      shift_ff  <= 8'h00;
      opc_ok_ff <= 1'b0;
    end
    else
    begin
      bitcnt_ff <= nxt_bitcnt;
      shift_ff  <= nxt_shift;
      opc_ok_ff <= nxt_opc_ok;
    end
  end

  always_comb
  begin
    nxt_data = data_ff;
    nxt_got  = got_ff;
    nxt_seq  = seq_ff;
    if (bitcnt_ff == 5'h00)
    begin
      nxt_got = 1'b0;
    end
    if (bitcnt_ff == `GSP_DATA_LAST)
    begin
      nxt_data = nxt_shift;
      nxt_got  = opc_ok_ff;
      nxt_seq  = seq_ff ^ opc_ok_ff;
    end
    // Only a whole byte boundary at the end counts
    nxt_frame_ok = nxt_got && (nxt_bitcnt[2:0] == 3'h0);
  end

  always_ff @(posedge sclk or negedge presetn)
  begin
    if (!presetn)
    begin
      data_ff     <= 8'h00;
      got_ff      <= 1'b0;
      frame_ok_ff <= 1'b0;
      seq_ff      <= 1'b0;
    end
    else
    begin
      data_ff     <= nxt_data;
      got_ff      <= nxt_got;
      frame_ok_ff <= nxt_frame_ok;
      seq_ff      <= nxt_seq;
    end
  end

  // ----------------------------------------
  // Crossings into the bus clock
  // ----------------------------------------
  logic cs_s;
  logic wp_s;
  logic ok_s;
  logic seq_s;

  // Select is synced active high so its reset value matches an idle pin
  gsp_sync u_sync_cs  (.clk(pclk), .rst_n(presetn), .din(~cs_n),       .dout(cs_s));
  gsp_sync u_sync_wp  (.clk(pclk), .rst_n(presetn), .din(wp_n),        .dout(wp_s));
  gsp_sync u_sync_ok  (.clk(pclk), .rst_n(presetn), .din(frame_ok_ff), .dout(ok_s));
  gsp_sync u_sync_seq (.clk(pclk), .rst_n(presetn), .din(seq_ff),      .dout(seq_s));

  // ----------------------------------------
  // Bus clock state
  // ----------------------------------------
  logic        cs_d_ff;
  logic        go1_ff;
  logic        go2_ff;
  logic        seen_ff;
  logic        nxt_seen;
  logic        lock_ff;
  logic        nxt_lock;
  logic        wel_ff;
  logic        nxt_wel;
  logic        susp_ff;
  logic        nxt_susp;
  gsp_act_t    last_ff;
  gsp_act_t    nxt_last;
  logic [31:0] sect_ff  [`GSP_SECT_WORDS];
  logic [31:0] nxt_sect [`GSP_SECT_WORDS];
  logic        pready_ff;
  logic        nxt_pready;
  logic        pslverr_ff;
  logic        nxt_pslverr;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic        setup;
  logic        done;
  logic        exec_go;
  logic        hw_lock;
  logic        sect_wr;
  logic        wel_set;
  logic        wel_clr;
  logic [3:0]  pat;
  logic [7:0]  stat_byte;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic is_mapped(input logic [`GSP_PADDR_W-1:0] a);
    is_mapped = (a == `GSP_OFF_STATUS) || (a == `GSP_OFF_CTRL) || (a == `GSP_OFF_SUSP) ||
                (a == `GSP_OFF_LAST) || ((a >= `GSP_OFF_SECT0) && (a <= `GSP_OFF_SECT3) &&
                (a[1:0] == 2'h0));
  endfunction

  function automatic logic is_sect(input logic [`GSP_PADDR_W-1:0] a);
    is_sect = (a >= `GSP_OFF_SECT0) && (a <= `GSP_OFF_SECT3);
  endfunction

  // Summary of software protection across all sectors
  function automatic logic [1:0] swp_of(input logic [127:0] s);
    if (&s)
      swp_of = `GSP_SWP_ALL;
    else if (|s)
      swp_of = `GSP_SWP_SOME;
    else
      swp_of = `GSP_SWP_NONE;
  endfunction

  assign sect_prot = {sect_ff[3], sect_ff[2], sect_ff[1], sect_ff[0]};
  // Pattern bits are only decoded; they never land in a register
  assign pat       = data_ff[`GSP_PAT_HI:`GSP_PAT_LO];
  // Status byte shows lock, pin, protection summary and latch
  always_comb
  begin
    stat_byte                                = 8'h00;
    stat_byte[`GSP_BIT_LOCK]                 = lock_ff;
    stat_byte[`GSP_ST_WP]                    = wp_s;
    stat_byte[`GSP_ST_SWP_HI:`GSP_ST_SWP_LO] = swp_of(sect_prot);
    stat_byte[`GSP_ST_WEL]                   = wel_ff;
  end

  // ----------------------------------------
  // APB access
  // ----------------------------------------
  assign setup   = psel && !penable;
  assign done    = psel && penable && pready_ff;
  assign sect_wr = done && pwrite && is_sect(paddr) && is_mapped(paddr);
  assign wel_set = done && pwrite && (paddr == `GSP_OFF_CTRL) && pwdata[`GSP_CTRL_WEL_SET];
  assign wel_clr = done && pwrite && (paddr == `GSP_OFF_CTRL) && pwdata[`GSP_CTRL_WEL_CLR];

  always_comb
  begin
    nxt_pready  = setup;
    nxt_pslverr = setup && !is_mapped(paddr);
    nxt_prdata  = 32'h00000000;
    if (setup && !pwrite && is_mapped(paddr))
    begin
      case (paddr)
        `GSP_OFF_STATUS: nxt_prdata = {24'h000000, stat_byte};
        `GSP_OFF_SUSP:   nxt_prdata = {31'h00000000, susp_ff};
        `GSP_OFF_LAST:   nxt_prdata = {29'h00000000, last_ff};
        default:
        begin
          if (is_sect(paddr))
            nxt_prdata = sect_ff[paddr[3:2]];
        end
      endcase
    end
  end

  // ----------------------------------------
  // Status byte write execution
  // ----------------------------------------
  // Two extra cycles let the frame flags settle behind chip select
  assign exec_go = go2_ff && ok_s && (seq_s != seen_ff);
  assign hw_lock = !wp_s && lock_ff;

  always_comb
  begin
    nxt_seen = seen_ff;
    nxt_lock = lock_ff;
    nxt_wel  = wel_ff;
    nxt_susp = susp_ff;
    nxt_last = last_ff;
    nxt_sect = sect_ff;
    if (done && pwrite && (paddr == `GSP_OFF_SUSP))
      nxt_susp = pwdata[`GSP_SUSP_BIT];
    if (sect_wr)
      nxt_sect[paddr[3:2]] = pwdata;
    if (wel_clr)
      nxt_wel = 1'b0;
    // Every select release consumes the toggle, so a refused frame cannot mask the next one
    if (go2_ff)
      nxt_seen = seq_s;
    if (exec_go)
    begin
      if (!wel_ff)
      begin
        nxt_last = GSP_ACT_NOWEL;
      end
      else
      begin
        nxt_wel = 1'b0;
        if (hw_lock)
        begin
          nxt_last = GSP_ACT_HWLOCK;
        end
        else if (lock_ff)
        begin
          // Soft lock: lock may clear, a global needs a second write
          nxt_lock = data_ff[`GSP_BIT_LOCK];
          nxt_last = GSP_ACT_SOFTLOCK;
        end
        else if ((pat == `GSP_PAT_ONES) && susp_ff)
        begin
          nxt_last = GSP_ACT_ABORT;
        end
        else
        begin
          nxt_lock = data_ff[`GSP_BIT_LOCK];
          case (pat)
            `GSP_PAT_ONES:
            begin
              for (int i = 0; i < `GSP_SECT_WORDS; i++)
                nxt_sect[i] = `GSP_SECT_RST;
              nxt_last = GSP_ACT_PROT;
            end
            `GSP_PAT_ZERO:
            begin
              for (int i = 0; i < `GSP_SECT_WORDS; i++)
                nxt_sect[i] = `GSP_SECT_CLR;
              nxt_last = GSP_ACT_UNPROT;
            end
            default: nxt_last = GSP_ACT_KEEP;
          endcase
        end
      end
    end
    // A latch set arriving with a clear wins
    if (wel_set)
      nxt_wel = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cs_d_ff    <= 1'b0;
      go1_ff     <= 1'b0;
      go2_ff     <= 1'b0;
      seen_ff    <= 1'b0;
      lock_ff    <= 1'b0;
      wel_ff     <= 1'b0;
      susp_ff    <= 1'b0;
      last_ff    <= GSP_ACT_NONE;
      for (int i = 0; i < `GSP_SECT_WORDS; i++)
        sect_ff[i] <= `GSP_SECT_RST;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end
    else
    begin
      cs_d_ff    <= cs_s;
      go1_ff     <= cs_d_ff && !cs_s;
      go2_ff     <= go1_ff;
      seen_ff    <= nxt_seen;
      lock_ff    <= nxt_lock;
      wel_ff     <= nxt_wel;
      susp_ff    <= nxt_susp;
      last_ff    <= nxt_last;
      sect_ff    <= nxt_sect;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff  <= nxt_prdata;
    end
  end

  assign prdata                 = prdata_ff;
  assign pready                 = pready_ff;
  assign pslverr                = pslverr_ff;
  assign protection_regs_locked = lock_ff;
  assign write_enable_latch     = wel_ff;
  assign last_action            = last_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  glob_protect_a: assert property (
    exec_go && wel_ff && !lock_ff && (pat == `GSP_PAT_ONES) && !susp_ff |=> (&sect_prot))
    else $error("global protect did not set all sectors");

  glob_unprotect_a: assert property (
    exec_go && wel_ff && !lock_ff && (pat == `GSP_PAT_ZERO) |=> (sect_prot == 128'h0))
    else $error("global unprotect did not clear all sectors");

  other_pattern_a: assert property (
    exec_go && (pat != `GSP_PAT_ONES) && (pat != `GSP_PAT_ZERO) && !sect_wr
    |=> $stable(sect_prot))
    else $error("non-global pattern changed sectors");

  lock_load_a: assert property (
    exec_go && wel_ff && !lock_ff && !((pat == `GSP_PAT_ONES) && susp_ff)
    |=> (lock_ff == $past(data_ff[`GSP_BIT_LOCK])))
    else $error("lock bit not loaded from written byte");

  hard_lock_a: assert property (
    exec_go && !wp_s && lock_ff && !sect_wr |=> $stable(lock_ff) && $stable(sect_prot))
    else $error("hardware locked write changed state");

  soft_lock_a: assert property (
    exec_go && wel_ff && wp_s && lock_ff && !sect_wr
    |=> $stable(sect_prot) && (lock_ff == $past(data_ff[`GSP_BIT_LOCK])))
    else $error("soft locked write misbehaved");

  susp_abort_a: assert property (
    exec_go && wel_ff && !lock_ff && (pat == `GSP_PAT_ONES) && susp_ff && !wel_set && !sect_wr
    |=> !wel_ff && $stable(sect_prot) && (last_ff == GSP_ACT_ABORT))
    else $error("protect during suspend not aborted");

  status_read_a: assert property (
    setup && !pwrite && (paddr == `GSP_OFF_STATUS)
    |=> (prdata_ff[`GSP_ST_WP] == $past(wp_s)) && (prdata_ff[`GSP_BIT_LOCK] == $past(lock_ff)))
    else $error("status read does not show pin and lock");

  chip_select_a: assert property (
    $changed(lock_ff) |-> $past(exec_go) && $past(go2_ff, 1))
    else $error("lock bit changed outside a completed write");
endmodule
`default_nettype wire

// ==== bench/gsp_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module gsp_host (
  // Link pins
  output logic sclk,
  output logic cs_n,
  output logic si
);
  // Clock stands still between frames
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si   = 1'b1;
  end
  // Opcode then data, MSB first; n below 16 cuts the frame short
  task automatic frame(input logic [15:0] bits, input int n);
    begin
      cs_n = 1'b0;
      #6;
      for (int i = 0; i < n; i++)
      begin
        si = bits[15-i];
        #6 sclk = 1'b1;
        #6 sclk = 1'b0;
      end
      #12 cs_n = 1'b1;
      // Released line: no pull, so show the inverse rather than a stale bit
      si = ~si;
    end
  endtask
endmodule
`default_nettype wire

// ==== bench/global_sector_protect_decode_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "gsp_params.svh"
module global_sector_protect_decode_tb_top;
  import gsp_pkg::*;
  localparam logic [127:0] ONES = {128{1'b1}};
  logic         pclk;
  logic         presetn;
  logic [7:0]   paddr;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [31:0]  pwdata;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         wp_n;
  logic         sclk;
  logic         cs_n;
  logic         si;
  logic [127:0] sect_prot;
  logic         protection_regs_locked;
  logic         write_enable_latch;
  gsp_act_t     last_action;
  logic [31:0]  rdat;
  logic         rerr;
  int           fails;
  int           check_count;

  gsp_decode dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .sclk, .cs_n, .si, .wp_n,
    .sect_prot, .protection_regs_locked, .write_enable_latch, .last_action);
  gsp_host host_u (.sclk, .cs_n, .si);

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic print_verdict();
    begin
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    begin
      check_count++;
      if (g !== e)
      begin
        $display("BAD %s expected %h seen %h", nm, e, g);
        fails++;
      end
    end
  endtask

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    begin
      n = 0;
      @(posedge pclk);
      paddr  <= a;
      pwrite <= w;
      pwdata <= d;
      psel   <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20)
      begin
        @(posedge pclk);
        n++;
      end
      if (n == 20)
      begin
        fails++;
        print_verdict();
      end
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    begin
      apb(a, 1'b0, 32'h00000000);
      chk(nm, 128'(e), 128'(rdat));
    end
  endtask

  // Status byte write; gap after cs_n rise covers result latency and spacing
  task automatic wsr(input logic [7:0] d, input logic [7:0] op, input int n, input logic en);
    begin
      if (en)
        apb(`GSP_OFF_CTRL, 1'b1, 32'h00000001);
      repeat (6) @(posedge pclk);
      host_u.frame({op, d}, n);
      repeat (20) @(posedge pclk);
    end
  endtask

  task automatic st(input logic [127:0] sp, input logic lk, input gsp_act_t act, input string nm);
    begin
      chk("sect_prot", sp, sect_prot);
      chk("lock", 128'(lk), 128'(protection_regs_locked));
      chk("wel", 128'(1'b0), 128'(write_enable_latch));
      chk("last_action", 128'(act), 128'(last_action));
      $display("test %s done", nm);
    end
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    fails = 0;
    check_count = 0;
    presetn <= 1'b0;
    paddr   <= 8'h00;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwrite  <= 1'b0;
    pwdata  <= 32'h00000000;
    wp_n    <= 1'b1;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    st(ONES, 1'b0, GSP_ACT_NONE, "reset");
    rd("status", `GSP_OFF_STATUS, 32'h0000001c);
    rd("susp", `GSP_OFF_SUSP, 32'h00000000);
    rd("unmapped", 8'h20, 32'h00000000);
    chk("pslverr", 128'(1'b1), 128'(rerr));
    wsr(8'h00, 8'h01, 16, 1'b1);
    st('0, 1'b0, GSP_ACT_UNPROT, "unprotect");
    rd("status", `GSP_OFF_STATUS, 32'h00000010);
    // Raw sector word shows any stray global action
    apb(`GSP_OFF_SECT0, 1'b1, 32'h00ff00f0);
    for (int p = 1; p < 15; p++)
    begin
      wsr({2'b01, 4'(p), 2'b11}, 8'h01, 16, 1'b1);
      chk("sect_prot", {96'h0, 32'h00ff00f0}, sect_prot);
    end
    st({96'h0, 32'h00ff00f0}, 1'b0, GSP_ACT_KEEP, "keep");
    rd("status", `GSP_OFF_STATUS, 32'h00000014);
    wsr(8'hbc, 8'h01, 16, 1'b1);
    st(ONES, 1'b1, GSP_ACT_PROT, "protect_lock");
    wsr(8'h00, 8'h01, 16, 1'b1);
    st(ONES, 1'b0, GSP_ACT_SOFTLOCK, "soft_lock");
    wsr(8'h00, 8'h01, 16, 1'b1);
    st('0, 1'b0, GSP_ACT_UNPROT, "second_write");
    wsr(8'h84, 8'h01, 16, 1'b1);
    wp_n <= 1'b0;
    wsr(8'h3c, 8'h01, 16, 1'b1);
    st('0, 1'b1, GSP_ACT_HWLOCK, "hw_lock");
    rd("status", `GSP_OFF_STATUS, 32'h00000080);
    wp_n <= 1'b1;
    wsr(8'h00, 8'h01, 16, 1'b1);
    st('0, 1'b0, GSP_ACT_SOFTLOCK, "unlock");
    apb(`GSP_OFF_SUSP, 1'b1, 32'h00000001);
    wp_n <= 1'b0;
    wsr(8'h3c, 8'h01, 16, 1'b1);
    st('0, 1'b0, GSP_ACT_ABORT, "abort");
    wsr(8'h00, 8'h01, 16, 1'b1);
    st('0, 1'b0, GSP_ACT_UNPROT, "susp_unprot");
    apb(`GSP_OFF_SUSP, 1'b1, 32'h00000000);
    wsr(8'h3c, 8'h01, 16, 1'b1);
    st(ONES, 1'b0, GSP_ACT_PROT, "wp_low_protect");
    wsr(8'h00, 8'h01, 16, 1'b0);
    st(ONES, 1'b0, GSP_ACT_NOWEL, "no_wel");
    // Refused frames: wrong opcode, short, not byte aligned
    wsr(8'h00, 8'h02, 16, 1'b1);
    wsr(8'h00, 8'h01, 8, 1'b0);
    wsr(8'h00, 8'h01, 12, 1'b0);
    wsr(8'h00, 8'h01, 15, 1'b0);
    chk("sect_prot", ONES, sect_prot);
    chk("wel", 128'(1'b1), 128'(write_enable_latch));
    rd("last", `GSP_OFF_LAST, 32'h00000007);
    apb(`GSP_OFF_CTRL, 1'b1, 32'h00000002);
    @(posedge pclk);
    chk("wel", 128'(1'b0), 128'(write_enable_latch));
    $display("test refused done");
    // Mid-run reset from a locked, unprotected state
    wsr(8'h80, 8'h01, 16, 1'b1);
    st('0, 1'b1, GSP_ACT_UNPROT, "lock_before_reset");
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    st(ONES, 1'b0, GSP_ACT_NONE, "mid_reset");
    wsr(8'h00, 8'h01, 16, 1'b1);
    st('0, 1'b0, GSP_ACT_UNPROT, "after_reset");
    print_verdict();
  end
endmodule
`default_nettype wire
